//--- common/flash_guard_pkg.sv
// Constants and types shared by the flash guard and its controller
// Behaviour
// - Scratch select steers reads and writes to scratchpad
// - Software keeps scratchpad accesses within 0x0000-0x03FF
// - Erase and write enables: write erases page
// - Erase ignores the written data byte
// - Write enable makes data writes program flash
// - Software erases a location before programming it
// - Control bits 7:3 read zero, writes ignored
// - Key 0xA5 then 0xF1 unlocks flash
// - Completed operation re-locks the flash
// - Wrong key write locks until reset
// - Operation while locked is suppressed, locks permanently
// - First key not 0xA5 locks permanently
// - Key register reads lock state in bits 1-0
// - Operation without supply monitor raises flash error reset
package flash_guard_pkg;
  // ==========================================================
  // Device registers
  localparam logic [7:0] PSC_ADDR = 8'h8F;
  localparam logic [7:0] KEY_ADDR = 8'hB6;
  localparam logic [7:0] PSC_RESET = 8'h00;
  localparam int WE_BIT = 0;
  localparam int PEE_BIT = 1;
  localparam int SCR_BIT = 2;
  localparam logic [7:0] KEY_FIRST = 8'hA5;
  localparam logic [7:0] KEY_SECOND = 8'hF1;
  localparam logic [1:0] LOCK_RD_LOCKED = 2'h0;
  localparam logic [1:0] LOCK_RD_KEY1 = 2'h1;
  localparam logic [1:0] LOCK_RD_OPEN = 2'h2;
  localparam logic [1:0] LOCK_RD_DEAD = 2'h3;
  localparam logic [7:0] ERASE_FILL = 8'hFF;
  // ==========================================================
  // Request kinds and answer codes
  localparam logic [1:0] CMD_SFR_WR = 2'h0;
  localparam logic [1:0] CMD_SFR_RD = 2'h1;
  localparam logic [1:0] CMD_XD_WR = 2'h2;
  localparam logic [1:0] CMD_CS_RD = 2'h3;
  localparam logic [1:0] ACK_OK = 2'h0;
  localparam logic [1:0] ACK_REFUSED = 2'h1;
  localparam logic [1:0] ACK_FLASH_ERR = 2'h2;
  localparam logic [1:0] ACK_NOT_FLASH = 2'h3;
  // ==========================================================
  // Controller APB map
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN = 8'h1C;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REFUSED = 1;
  localparam int IRQ_FLASH_ERR = 2;
  localparam logic [2:0] IRQ_EN_RESET = 3'h0;
  // ==========================================================
  // State types
  typedef enum logic [1:0] {
    LK_LOCKED, LK_KEY1, LK_OPEN, LK_DEAD
  } lock_t;
  typedef enum logic [1:0] {
    CS_IDLE, CS_ISSUE, CS_WAIT
  } ctrl_t;
endpackage

//--- common/flash_guard_if.sv
// Link between the flash guard and its controller
`timescale 1ns/100ps
interface flash_guard_if;
  // Requests; strobes are one-cycle pulses, address and data held
  logic req_sfr_wr;
  logic req_sfr_rd;
  logic req_xd_wr;
  logic req_cs_rd;
  logic [15:0] req_addr;
  logic [7:0] req_data;
  // Answers
  logic ack;
  logic [1:0] ack_code;
  logic [7:0] ack_data;
  logic busy;

  modport device (
    input req_sfr_wr, req_sfr_rd, req_xd_wr, req_cs_rd,
    input req_addr, req_data,
    output ack, ack_code, ack_data, busy
  );
  modport ctrl (
    output req_sfr_wr, req_sfr_rd, req_xd_wr, req_cs_rd,
    output req_addr, req_data,
    input ack, ack_code, ack_data, busy
  );
endinterface

//--- core/flash_write_erase_guard.sv
// Flash write and erase guard with key lock and sector steering
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
module flash_write_erase_guard
  import flash_guard_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Controller link
  flash_guard_if.device lnk,
  // Flash array
  input wire logic fl_done,
  output logic fl_rd,
  output logic fl_prog,
  output logic fl_erase,
  output logic fl_scratch,
  output logic [15:0] fl_addr,
  output logic [7:0] fl_data,
  // Supply monitor
  input wire logic vdd_mon_en,
  input wire logic vdd_rst_en,
  output logic flash_err_reset
);

  // ==========================================================
  // Supply monitor synchronisers
  logic [1:0] sup_meta_ff;
  logic [1:0] sup_ff;
  logic supply_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_meta_ff <= 2'h0;
      sup_ff <= 2'h0;
    end else begin
      sup_meta_ff <= {vdd_rst_en, vdd_mon_en};
      sup_ff <= sup_meta_ff;
    end
  end

  // Both monitor and its reset source must be on
  assign supply_ok = &sup_ff;

  // ==========================================================
  // State and output registers
  logic [2:0] psc_ff;
  logic [2:0] nxt_psc;
  lock_t lock_ff;
  lock_t nxt_lock;
  logic busy_ff;
  logic nxt_busy;
  logic ack_ff;
  logic nxt_ack;
  logic [1:0] ack_code_ff;
  logic [1:0] nxt_ack_code;
  logic [7:0] ack_data_ff;
  logic [7:0] nxt_ack_data;
  logic fl_rd_ff;
  logic nxt_fl_rd;
  logic fl_prog_ff;
  logic nxt_fl_prog;
  logic fl_erase_ff;
  logic nxt_fl_erase;
  logic fl_scratch_ff;
  logic nxt_fl_scratch;
  logic [15:0] fl_addr_ff;
  logic [15:0] nxt_fl_addr;
  logic [7:0] fl_data_ff;
  logic [7:0] nxt_fl_data;
  logic err_rst_ff;
  logic nxt_err_rst;
  logic [1:0] lock_code;

  // ==========================================================
  // Lock state as seen by software
  always_comb begin
    case (lock_ff)
      LK_LOCKED: lock_code = LOCK_RD_LOCKED;
      LK_KEY1: lock_code = LOCK_RD_KEY1;
      LK_OPEN: lock_code = LOCK_RD_OPEN;
      LK_DEAD: lock_code = LOCK_RD_DEAD;
      default: lock_code = LOCK_RD_DEAD;
    endcase
  end

  // ==========================================================
  // Request handling
  always_comb begin
    nxt_psc = psc_ff;
    nxt_lock = lock_ff;
    nxt_busy = busy_ff;
    nxt_ack = 1'b0;
    nxt_ack_code = ACK_OK;
    nxt_ack_data = 8'h00;
    nxt_fl_rd = 1'b0;
    nxt_fl_prog = 1'b0;
    nxt_fl_erase = 1'b0;
    nxt_fl_scratch = fl_scratch_ff;
    nxt_fl_addr = fl_addr_ff;
    nxt_fl_data = fl_data_ff;
    nxt_err_rst = 1'b0;
    if (busy_ff) begin
      // Core is stalled until the array finishes
      if (fl_done) begin
        nxt_busy = 1'b0;
        nxt_lock = LK_LOCKED;
        nxt_ack = 1'b1;
      end
    end else if (lnk.req_sfr_wr) begin
      nxt_ack = 1'b1;
      if (lnk.req_addr[7:0] == PSC_ADDR) begin
        // Upper bits are not stored
        nxt_psc = lnk.req_data[2:0];
      end else if (lnk.req_addr[7:0] == KEY_ADDR) begin
        case (lock_ff)
          LK_LOCKED: begin
            if (lnk.req_data == KEY_FIRST) begin
              nxt_lock = LK_KEY1;
            end else begin
              nxt_lock = LK_DEAD;
            end
          end
          LK_KEY1: begin
            if (lnk.req_data == KEY_SECOND) begin
              nxt_lock = LK_OPEN;
            end else begin
              nxt_lock = LK_DEAD;
            end
          end
          // A third key write breaks the order
          LK_OPEN: nxt_lock = LK_DEAD;
          LK_DEAD: nxt_lock = LK_DEAD;
          default: nxt_lock = LK_DEAD;
        endcase
      end
    end else if (lnk.req_sfr_rd) begin
      nxt_ack = 1'b1;
      if (lnk.req_addr[7:0] == PSC_ADDR) begin
        nxt_ack_data = {5'h00, psc_ff};
      end else if (lnk.req_addr[7:0] == KEY_ADDR) begin
        nxt_ack_data = {6'h00, lock_code};
      end
    end else if (lnk.req_xd_wr) begin
      nxt_ack = 1'b1;
      if (!psc_ff[WE_BIT]) begin
        // Plain data write, flash untouched
        nxt_ack_code = ACK_NOT_FLASH;
      end else if (lock_ff != LK_OPEN) begin
        nxt_lock = LK_DEAD;
        nxt_ack_code = ACK_REFUSED;
      end else if (!supply_ok) begin
        nxt_err_rst = 1'b1;
        nxt_ack_code = ACK_FLASH_ERR;
      end else begin
        // Answer waits for the array
        nxt_ack = 1'b0;
        nxt_busy = 1'b1;
        nxt_fl_scratch = psc_ff[SCR_BIT];
        nxt_fl_addr = lnk.req_addr;
        if (psc_ff[PEE_BIT]) begin
          nxt_fl_erase = 1'b1;
          nxt_fl_data = ERASE_FILL;
        end else begin
          nxt_fl_prog = 1'b1;
          nxt_fl_data = lnk.req_data;
        end
      end
    end else if (lnk.req_cs_rd) begin
      nxt_ack = 1'b1;
      nxt_fl_rd = 1'b1;
      nxt_fl_scratch = psc_ff[SCR_BIT];
      nxt_fl_addr = lnk.req_addr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_ff <= PSC_RESET[2:0];
      lock_ff <= LK_LOCKED;
      busy_ff <= 1'b0;
      ack_ff <= 1'b0;
      ack_code_ff <= ACK_OK;
      ack_data_ff <= 8'h00;
      fl_rd_ff <= 1'b0;
      fl_prog_ff <= 1'b0;
      fl_erase_ff <= 1'b0;
      fl_scratch_ff <= 1'b0;
      fl_addr_ff <= 16'h0000;
      fl_data_ff <= 8'h00;
      err_rst_ff <= 1'b0;
    end else begin
      psc_ff <= nxt_psc;
      lock_ff <= nxt_lock;
      busy_ff <= nxt_busy;
      ack_ff <= nxt_ack;
      ack_code_ff <= nxt_ack_code;
      ack_data_ff <= nxt_ack_data;
      fl_rd_ff <= nxt_fl_rd;
      fl_prog_ff <= nxt_fl_prog;
      fl_erase_ff <= nxt_fl_erase;
      fl_scratch_ff <= nxt_fl_scratch;
      fl_addr_ff <= nxt_fl_addr;
      fl_data_ff <= nxt_fl_data;
      err_rst_ff <= nxt_err_rst;
    end
  end

  // ==========================================================
  // Outputs
  assign lnk.ack = ack_ff;
  assign lnk.ack_code = ack_code_ff;
  assign lnk.ack_data = ack_data_ff;
  assign lnk.busy = busy_ff;
  assign fl_rd = fl_rd_ff;
  assign fl_prog = fl_prog_ff;
  assign fl_erase = fl_erase_ff;
  assign fl_scratch = fl_scratch_ff;
  assign fl_addr = fl_addr_ff;
  assign fl_data = fl_data_ff;
  assign flash_err_reset = err_rst_ff;

endmodule // flash_write_erase_guard

//--- core/flash_guard_ctrl.sv
// APB controller that drives the flash guard on behalf of software
`timescale 1ns/100ps
module flash_guard_ctrl
  import flash_guard_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Guard link
  flash_guard_if.ctrl lnk
);

  // ==========================================================
  // Registers
  logic pready_ff;
  logic [31:0] prdata_ff;
  logic [15:0] addr_ff;
  logic [7:0] wdata_ff;
  logic [7:0] rdata_ff;
  logic [1:0] kind_ff;
  logic [1:0] code_ff;
  logic [2:0] ist_ff;
  logic [2:0] ien_ff;
  logic irq_ff;
  ctrl_t st_ff;
  logic [31:0] nxt_prdata;
  logic [15:0] nxt_addr;
  logic [7:0] nxt_wdata;
  logic [7:0] nxt_rdata;
  logic [1:0] nxt_kind;
  logic [1:0] nxt_code;
  logic [2:0] nxt_ist;
  logic [2:0] nxt_ien;
  ctrl_t nxt_st;
  logic [2:0] ev;
  logic wr_en;
  logic [7:0] ofs;

  assign wr_en = psel && penable && pready_ff && pwrite;
  assign ofs = paddr[7:0];

  // ==========================================================
  // Register access and command sequencing
  always_comb begin
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    nxt_kind = kind_ff;
    nxt_code = code_ff;
    nxt_ien = ien_ff;
    nxt_st = st_ff;
    nxt_prdata = 32'h0000_0000;
    ev = 3'h0;
    // Read data chosen in the setup cycle, driven from the first access cycle
    if (psel && !penable && (paddr[11:8] == 4'h0)) begin
      case (ofs)
        OFS_ADDR: nxt_prdata = {16'h0000, addr_ff};
        OFS_WDATA: nxt_prdata = {24'h000000, wdata_ff};
        OFS_RDATA: nxt_prdata = {24'h000000, rdata_ff};
        OFS_STATUS: nxt_prdata = {26'h0, kind_ff, code_ff,
                                  lnk.busy, st_ff != CS_IDLE};
        OFS_IRQ_STAT: nxt_prdata = {29'h0, ist_ff};
        OFS_IRQ_EN: nxt_prdata = {29'h0, ien_ff};
        default: nxt_prdata = 32'h0000_0000;
      endcase
    end
    if (wr_en && (paddr[11:8] == 4'h0)) begin
      case (ofs)
        OFS_ADDR: nxt_addr = pwdata[15:0];
        OFS_WDATA: nxt_wdata = pwdata[7:0];
        OFS_IRQ_EN: nxt_ien = pwdata[2:0];
        // Commands during a transfer are dropped
        OFS_CMD: begin
          if (st_ff == CS_IDLE) begin
            nxt_kind = pwdata[1:0];
            nxt_st = CS_ISSUE;
          end
        end
        default: nxt_ien = ien_ff;
      endcase
    end
    case (st_ff)
      // Start of a command is decided by the register write above
      CS_IDLE: begin
      end
      CS_ISSUE: nxt_st = CS_WAIT;
      CS_WAIT: begin
        if (lnk.ack) begin
          nxt_st = CS_IDLE;
          nxt_code = lnk.ack_code;
          ev[IRQ_DONE] = 1'b1;
          ev[IRQ_REFUSED] = lnk.ack_code == ACK_REFUSED;
          ev[IRQ_FLASH_ERR] = lnk.ack_code == ACK_FLASH_ERR;
          if (kind_ff == CMD_SFR_RD) begin
            nxt_rdata = lnk.ack_data;
          end
        end
      end
      default: nxt_st = CS_IDLE;
    endcase
    // Set wins over clear
    nxt_ist = ist_ff;
    if (wr_en && ofs == OFS_IRQ_CLR && paddr[11:8] == 4'h0) begin
      nxt_ist = ist_ff & ~pwdata[2:0];
    end
    nxt_ist = nxt_ist | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      addr_ff <= 16'h0000;
      wdata_ff <= 8'h00;
      rdata_ff <= 8'h00;
      kind_ff <= CMD_SFR_WR;
      code_ff <= ACK_OK;
      ist_ff <= 3'h0;
      ien_ff <= IRQ_EN_RESET;
      irq_ff <= 1'b0;
      st_ff <= CS_IDLE;
    end else begin
      pready_ff <= psel && !penable;
      prdata_ff <= nxt_prdata;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      kind_ff <= nxt_kind;
      code_ff <= nxt_code;
      ist_ff <= nxt_ist;
      ien_ff <= nxt_ien;
      irq_ff <= |(nxt_ist & nxt_ien);
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs; requests pulse only in the issue state
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = 1'b0;
  assign irq = irq_ff;
  assign lnk.req_sfr_wr = st_ff == CS_ISSUE && kind_ff == CMD_SFR_WR;
  assign lnk.req_sfr_rd = st_ff == CS_ISSUE && kind_ff == CMD_SFR_RD;
  assign lnk.req_xd_wr = st_ff == CS_ISSUE && kind_ff == CMD_XD_WR;
  assign lnk.req_cs_rd = st_ff == CS_ISSUE && kind_ff == CMD_CS_RD;
  assign lnk.req_addr = addr_ff;
  assign lnk.req_data = wdata_ff;

endmodule // flash_guard_ctrl

//--- verification/flash_guard_monitor.sv
// Checker for the link between the flash guard and its controller
`timescale 1ns/100ps
module flash_guard_monitor
  import flash_guard_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link
  input wire logic req_sfr_wr,
  input wire logic req_sfr_rd,
  input wire logic req_xd_wr,
  input wire logic req_cs_rd,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_data,
  input wire logic ack,
  input wire logic [1:0] ack_code,
  input wire logic [7:0] ack_data,
  input wire logic busy
);
  // ==========================================================
  // Permanent lock; only sure cases, so no false alarms
  logic dead_ff;
  logic nxt_dead;
  always_comb begin
    nxt_dead = dead_ff;
    if (req_sfr_wr && !busy && req_addr[7:0] == KEY_ADDR &&
        req_data != KEY_FIRST && req_data != KEY_SECOND) begin
      nxt_dead = 1'b1;
    end
    if (ack && ack_code == ACK_REFUSED) begin
      nxt_dead = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dead_ff <= 1'b0;
    end else begin
      dead_ff <= nxt_dead;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Assertions
  chk_sfr_wr_ack: assert property (req_sfr_wr && !busy |=> ack)
    else $error("register write not answered");
  chk_key_read: assert property (req_sfr_rd && !busy &&
    req_addr[7:0] == KEY_ADDR |=> ack && ack_data[7:2] == 6'h00)
    else $error("key register read malformed");
  chk_ctrl_upper: assert property (req_sfr_rd && !busy &&
    req_addr[7:0] == PSC_ADDR |=> ack && ack_data[7:3] == 5'h00)
    else $error("control register upper bits not zero");
  chk_dead_refuse: assert property (dead_ff && req_xd_wr && !busy
    |=> ack && ack_code != ACK_OK)
    else $error("flash write accepted while locked");
  chk_dead_key_read: assert property (dead_ff && req_sfr_rd &&
    req_addr[7:0] == KEY_ADDR |=> ack_data[1:0] == LOCK_RD_DEAD)
    else $error("permanent lock not reported");
  chk_xd_answer: assert property (req_xd_wr && !busy |=> ack != busy)
    else $error("data write neither answered nor started");
  chk_done_ack: assert property ($fell(busy) |-> ack && ack_code == ACK_OK)
    else $error("flash operation end without good answer");
  chk_code_rd_ack: assert property (req_cs_rd && !busy |=> ack && !busy)
    else $error("code read not answered");
  cover property (ack && ack_code == ACK_REFUSED);
  cover property ($fell(busy));
  cover property (ack && ack_code == ACK_FLASH_ERR);
endmodule // flash_guard_monitor

//--- verification/tb_top.sv
// Testbench for the flash guard and its APB controller
`timescale 1ns/100ps
module tb_top;
  import flash_guard_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, st, last_op;
  logic fl_done, fl_rd, fl_prog, fl_erase, fl_scratch;
  logic [15:0] fl_addr;
  logic [7:0] fl_data;
  logic vdd_mon_en, vdd_rst_en, flash_err_reset;
  logic [1:0] dcnt;
  logic [7:0] bad [3] = '{8'h12, 8'hF1, 8'h00};
  int failures = 0;
  int tests_run = 0;
  int n_prog, n_erase, n_rd, n_err;
  flash_guard_if lnk_if();
  flash_write_erase_guard i_flash_write_erase_guard(.pclk(pclk),
    .presetn(presetn), .lnk(lnk_if), .fl_done(fl_done), .fl_rd(fl_rd),
    .fl_prog(fl_prog), .fl_erase(fl_erase), .fl_scratch(fl_scratch),
    .fl_addr(fl_addr), .fl_data(fl_data), .vdd_mon_en(vdd_mon_en),
    .vdd_rst_en(vdd_rst_en), .flash_err_reset(flash_err_reset));
  flash_guard_ctrl i_flash_guard_ctrl(.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .lnk(lnk_if));
  flash_guard_monitor i_flash_guard_monitor(.pclk(pclk), .presetn(presetn),
    .req_sfr_wr(lnk_if.req_sfr_wr), .req_sfr_rd(lnk_if.req_sfr_rd),
    .req_xd_wr(lnk_if.req_xd_wr), .req_cs_rd(lnk_if.req_cs_rd),
    .req_addr(lnk_if.req_addr), .req_data(lnk_if.req_data),
    .ack(lnk_if.ack), .ack_code(lnk_if.ack_code),
    .ack_data(lnk_if.ack_data), .busy(lnk_if.busy));
  always #20 pclk = ~pclk;
  // ==========================================================
  // Flash array; answers late, as a slow part would
  always @(posedge pclk) begin
    fl_done <= (dcnt == 2'h1);
    dcnt <= (fl_prog | fl_erase) ? 2'h3 : dcnt - 2'(dcnt != 2'h0);
    n_prog += int'(fl_prog);
    n_erase += int'(fl_erase);
    n_rd += int'(fl_rd);
    n_err += int'(flash_err_reset);
    if (fl_prog | fl_erase | fl_rd) begin
      last_op = {7'h00, fl_scratch, fl_addr, fl_data};
    end
  end
  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {4'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [1:0] k, input logic [15:0] a,
                     input logic [7:0] d);
    apb(1'b1, OFS_ADDR, {16'h0000, a});
    apb(1'b1, OFS_WDATA, {24'h000000, d});
    apb(1'b1, OFS_CMD, {30'h0, k});
    st = 32'h1;
    for (int i = 0; i < 40 && st[0] !== 1'b0; i++) begin
      apb(1'b0, OFS_STATUS, 32'h0);
      st = q;
    end
  endtask
  task automatic sfr(input logic [7:0] a, input logic [7:0] d);
    cmd(CMD_SFR_WR, {8'h00, a}, d);
  endtask
  task automatic peek(input logic [7:0] a, input logic [7:0] exp);
    cmd(CMD_SFR_RD, {8'h00, a}, 8'h00);
    apb(1'b0, OFS_RDATA, 32'h0);
    check(q, {24'h000000, exp});
  endtask
  task automatic code(input logic [1:0] exp);
    check({30'h0, st[3:2]}, {30'h0, exp});
  endtask
  task automatic unlock();
    sfr(KEY_ADDR, KEY_FIRST);
    sfr(KEY_ADDR, KEY_SECOND);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  task automatic summarize();
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    summarize();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, fl_done} = '0;
    {vdd_mon_en, vdd_rst_en, dcnt, last_op} = {2'h3, 34'h0};
    {n_prog, n_erase, n_rd, n_err} = '0;
    do_reset();
    peek(PSC_ADDR, PSC_RESET);
    peek(KEY_ADDR, {6'h00, LOCK_RD_LOCKED});
    apb(1'b0, 8'h20, 32'h0);
    check(q, 32'h0);
    check({31'h0, pslverr}, 32'h0);
    sfr(PSC_ADDR, 8'hFF);
    peek(PSC_ADDR, 8'h07);
    sfr(PSC_ADDR, 8'h00);
    cmd(CMD_XD_WR, 16'h1234, 8'h5A);
    code(ACK_NOT_FLASH);
    apb(1'b1, OFS_IRQ_EN, 32'h1);
    sfr(KEY_ADDR, KEY_FIRST);
    peek(KEY_ADDR, {6'h00, LOCK_RD_KEY1});
    sfr(KEY_ADDR, KEY_SECOND);
    peek(KEY_ADDR, {6'h00, LOCK_RD_OPEN});
    sfr(PSC_ADDR, 8'h01);
    cmd(CMD_XD_WR, 16'h1234, 8'h5A);
    code(ACK_OK);
    check(n_prog, 32'h1);
    check(last_op, 32'h0012345A);
    peek(KEY_ADDR, {6'h00, LOCK_RD_LOCKED});
    check({31'h0, irq}, 32'h1);
    apb(1'b1, OFS_IRQ_EN, 32'h0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    // Status stays sticky while the line is masked
    check({30'h0, q[0], irq}, 32'h2);
    apb(1'b1, OFS_IRQ_CLR, 32'h7);
    apb(1'b1, OFS_IRQ_EN, 32'h1);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    check({q[2:0], irq}, 4'h0);
    // Scratch sector kept within its range
    unlock();
    sfr(PSC_ADDR, 8'h07);
    cmd(CMD_XD_WR, 16'h0345, 8'h3C);
    code(ACK_OK);
    check(n_erase, 32'h1);
    check(n_prog, 32'h1);
    check(last_op, {8'h01, 16'h0345, ERASE_FILL});
    // Program only the location just erased
    unlock();
    sfr(PSC_ADDR, 8'h05);
    cmd(CMD_XD_WR, 16'h0345, 8'h3C);
    check(last_op, {8'h01, 16'h0345, 8'h3C});
    cmd(CMD_CS_RD, 16'h0010, 8'h00);
    check(n_rd, 32'h1);
    check(last_op[31:8], 24'h010010);
    sfr(PSC_ADDR, 8'h00);
    cmd(CMD_CS_RD, 16'h0010, 8'h00);
    check(last_op[31:8], 24'h000010);
    // Supply monitor reset source off
    unlock();
    sfr(PSC_ADDR, 8'h01);
    vdd_rst_en <= 1'b0;
    repeat (3) @(posedge pclk);
    cmd(CMD_XD_WR, 16'h0200, 8'h11);
    code(ACK_FLASH_ERR);
    check(n_err, 32'h1);
    check(n_prog, 32'h2);
    vdd_rst_en <= 1'b1;
    repeat (3) @(posedge pclk);
    cmd(CMD_XD_WR, 16'h0200, 8'h11);
    code(ACK_OK);
    // Write while locked
    cmd(CMD_XD_WR, 16'h0201, 8'h22);
    code(ACK_REFUSED);
    peek(KEY_ADDR, {6'h00, LOCK_RD_DEAD});
    unlock();
    peek(KEY_ADDR, {6'h00, LOCK_RD_DEAD});
    cmd(CMD_XD_WR, 16'h0201, 8'h22);
    code(ACK_REFUSED);
    check(n_prog, 32'h3);
    do_reset();
    peek(PSC_ADDR, PSC_RESET);
    peek(KEY_ADDR, {6'h00, LOCK_RD_LOCKED});
    sfr(KEY_ADDR, KEY_FIRST);
    sfr(KEY_ADDR, KEY_FIRST);
    peek(KEY_ADDR, {6'h00, LOCK_RD_DEAD});
    foreach (bad[i]) begin
      do_reset();
      sfr(KEY_ADDR, bad[i]);
      peek(KEY_ADDR, {6'h00, LOCK_RD_DEAD});
    end
    summarize();
  end
endmodule // tb_top
